// File: dv/spc_far.sv
`timescale 1ns/1ps
module spc_far (
	// timing mode
	input  wire logic clock_idle_level,
	input  wire logic capture_edge_sel,
	// link pins
	input  wire logic sck_i,
	input  wire logic mosi_i,
	input  wire logic miso_i,
	output logic      sck_o,
	output logic      ss_n_o,
	output logic      mosi_o,
	output logic      miso_o
);
	logic [7:0] sh;
	logic [7:0] rx;
	int         ne;
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
		miso_o = 1'b0;
		ne = 0;
	end
	task automatic nxt(inout logic [7:0] s, output logic o);
		o = s[7];
		s = {s[6:0], ~s[7]};
	endtask
	// ****
	// far slave, follows the device clock
	// ****
	task automatic load(input logic [7:0] v);
		sh = v;
		ne = 0;
		if (!capture_edge_sel) nxt(sh, miso_o);
	endtask
	// one slave only, select held high on the device
	always @(sck_i) begin
		if (ss_n_o) begin
			ne = ne + 1;
			if ((ne % 2 == 1) != capture_edge_sel)
				rx = {rx[6:0], mosi_i};
			else if (ne < 16)
				nxt(sh, miso_o);
			if (ne == 16) begin
				ne = 0;
				miso_o = ~miso_o;
			end
		end
	end
	// ****
	// far master, clock still between frames
	// ****
	task automatic send(input logic [7:0] tx, input logic keep, output logic [7:0] got);
		// step off the pclk edge so the synchronisers never race the pins
		#10;
		sck_o = clock_idle_level;
		#200;
		ss_n_o = 1'b0;
		#400;
		if (!capture_edge_sel) nxt(tx, mosi_o);
		#200;
		for (int e = 1; e <= 16; e++) begin
			sck_o = ~sck_o;
			if ((e % 2 == 1) != capture_edge_sel)
				got = {got[6:0], miso_i};
			else
				nxt(tx, mosi_o);
			#200;
		end
		mosi_o = ~mosi_o;
		ss_n_o = keep ? 1'b0 : 1'b1; // high between bytes unless keep is set
		#400;
	endtask
	task automatic sel(input logic v);
		ss_n_o <= v;
	endtask
endmodule

// File: dv/tb_spi_phase_collision_fault.sv
`timescale 1ns/1ps
module tb_spi_phase_collision_fault;
	import spc_pkg::*;
	logic            pclk = 1'b0;
	logic            presetn, psel, penable, pwrite, halt_mode;
	logic [3:0]      paddr;
	logic [31:0]     pwdata, prdata;
	logic            pready, pslverr, irq, err, pol, pha;
	logic [2:0]      rt;
	logic            f_sck, f_ss, f_mosi, f_miso, sck_w, mosi_w, miso_w;
	logic [7:0]      r, a, b, c;
	int              seed, n_mismatch, compares, cyc;
	spc_pin_in_type  pin_i;
	spc_pin_out_type po, poe, hp;
	always #25 pclk = ~pclk;
	// ****
	// pins: enable low means the device drives
	// ****
	assign sck_w = poe.sck ? f_sck : po.sck;
	assign mosi_w = poe.mosi ? f_mosi : po.mosi;
	assign miso_w = poe.miso ? f_miso : po.miso;
	assign pin_i = {sck_w, f_ss, mosi_w, miso_w};
	spc_core spc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_i(pin_i), .pin_o(po), .pin_oe_n(poe),
		.halt_mode(halt_mode), .irq(irq));
	spc_far spc_far_i (.clock_idle_level(pol), .capture_edge_sel(pha), .sck_i(sck_w), .mosi_i(mosi_w),
		.miso_i(miso_w), .sck_o(f_sck), .ss_n_o(f_ss), .mosi_o(f_mosi), .miso_o(f_miso));
	// ****
	// tasks
	// ****
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [3:0] ad, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: a dead slave runs into the cycle ceiling
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wirq;
		int t;
		t = 0;
		while (irq !== 1'b1 && t < 2000) begin
			@(posedge pclk);
			t++;
		end
		chk({7'h0, irq}, 8'h01, "irq");
	endtask
	function automatic logic [7:0] ctl(input logic on, input logic m);
		return {1'b1, on, rt[2], m, pol, pha, rt[1:0]};
	endfunction
	// cut a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			close_out;
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		seed = 32'h92e9ec29;
		{psel, penable, pwrite, paddr, pwdata, halt_mode, pol, pha, rt} = '0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, SPC_OFS_CTRL, 0); chk(r, SPC_CTRL_RST, "ctrl reset");
		apb(0, SPC_OFS_STAT, 0); chk(r, 8'h00, "stat reset");
		apb(0, SPC_OFS_DATA, 0); chk(r, SPC_DATA_RST, "data reset");
		apb(0, 4'hc, 0); chk({7'h0, err}, 8'h01, "unmapped");
		// master in all four modes; collision, blocked write and halt among them
		for (int m = 0; m < 4; m++) begin
			{pol, pha} = 2'(m);
			// half periods of 4, 8, 16 and 64 cycles; the slowest sets the irq wait
			rt = 3'(m == 2 ? 6 : m);
			apb(1, SPC_OFS_CTRL, ctl(1, 1));
			repeat (4) @(posedge pclk);
			chk({6'h0, poe.sck, po.sck}, {7'h0, pol}, "idle");
			a = 8'($random(seed));
			b = 8'($random(seed));
			spc_far_i.load(b);
			apb(1, SPC_OFS_DATA, a);
			if (m == 1) begin
				apb(1, SPC_OFS_DATA, ~a);
				chk({7'h0, irq}, 8'h00, "clash irq");
			end
			if (m == 2) begin
				halt_mode <= 1'b1;
				repeat (3) @(posedge pclk);
				hp = po;
				repeat (30) @(posedge pclk);
				chk({5'h0, po}, {5'h0, hp}, "halt");
				halt_mode <= 1'b0;
			end
			wirq;
			if (m == 0) begin
				apb(1, SPC_OFS_DATA, 8'h5a);
				repeat (20) @(posedge pclk);
				chk(spc_far_i.ne[7:0], 8'h00, "blocked");
			end
			apb(0, SPC_OFS_STAT, 0); chk(r, {1'b1, m == 1, 6'h0}, "stat");
			apb(0, SPC_OFS_DATA, 0); chk(r, b, "master rx");
			chk(spc_far_i.rx, a, "far rx");
			apb(0, SPC_OFS_STAT, 0); chk(r, 8'h00, "cleared");
		end
		// select pulled low on an active master
		spc_far_i.sel(1'b0);
		repeat (8) @(posedge pclk);
		chk({7'h0, irq}, 8'h01, "fault irq");
		chk({5'h0, poe}, 8'h07, "released");
		apb(0, SPC_OFS_CTRL, 0); chk(r, ctl(0, 0), "fault ctrl");
		apb(1, SPC_OFS_CTRL, ctl(1, 1));
		apb(0, SPC_OFS_CTRL, 0); chk(r, ctl(0, 0), "set blocked");
		spc_far_i.sel(1'b1);
		apb(0, SPC_OFS_STAT, 0); chk(r, 8'h10, "fault");
		apb(1, SPC_OFS_CTRL, ctl(1, 1));
		apb(0, SPC_OFS_CTRL, 0); chk(r, ctl(1, 1), "restored");
		apb(0, SPC_OFS_STAT, 0); chk(r, 8'h00, "fault clear");
		// slave, phase 0: write under select, overrun, echo
		{pol, pha} = 2'h0;
		apb(1, SPC_OFS_CTRL, ctl(1, 0));
		spc_far_i.sel(1'b0);
		repeat (4) @(posedge pclk);
		apb(1, SPC_OFS_DATA, 8'h3c);
		apb(0, SPC_OFS_STAT, 0); chk(r, 8'h40, "slave clash");
		apb(0, SPC_OFS_DATA, 0);
		spc_far_i.sel(1'b1);
		a = 8'($random(seed));
		b = 8'($random(seed));
		c = 8'($random(seed));
		apb(1, SPC_OFS_DATA, c);
		spc_far_i.send(a, 1'b0, r); chk(r, c, "slave tx");
		spc_far_i.send(b, 1'b0, r); chk(r, a, "echo");
		apb(0, SPC_OFS_STAT, 0); chk(r, 8'h80, "overrun");
		apb(0, SPC_OFS_DATA, 0); chk(r, a, "first kept");
		// slave, phase 1: select stays low across two bytes
		pha = 1'b1;
		apb(1, SPC_OFS_CTRL, ctl(1, 0));
		apb(1, SPC_OFS_DATA, c);
		spc_far_i.send(a, 1'b1, r); chk(r, c, "phase1 tx");
		apb(0, SPC_OFS_STAT, 0);
		apb(1, SPC_OFS_DATA, b);
		spc_far_i.send(a, 1'b0, r); chk(r, b, "kept select");
		apb(0, SPC_OFS_STAT, 0); chk(r, 8'h80, "no clash");
		apb(0, SPC_OFS_DATA, 0); chk(r, a, "phase1 rx");
		close_out;
	end
endmodule

// File: hw/spc_core.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module spc_core (
	// apb slave
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [spc_pkg::SPC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// serial pins
	input  wire spc_pkg::spc_pin_in_type      pin_i,
	output spc_pkg::spc_pin_out_type          pin_o,
	output spc_pkg::spc_pin_out_type          pin_oe_n,
	// cpu power modes
	input  wire logic                         halt_mode,
	output logic                              irq
);
	import spc_pkg::*;

	// ****************************************
	// state
	// ****************************************
	spc_ctrl_type      ctrl_q;
	spc_ctrl_type      ctrl_wr;
	spc_pin_in_type    sync1_q;
	spc_pin_in_type    sync2_q;
	logic              sck_prev_q;
	spc_mst_state_type state_q;
	logic [6:0]        div_q;
	logic [6:0]        half;
	logic              sck_q;
	logic [2:0]        bit_q;
	logic [7:0]        sh_q;
	logic              samp_q;
	logic              out_q;
	logic              locked_q;
	logic [7:0]        rx_q;
	logic              done_q;
	logic              done_arm_q;
	logic              clash_q;
	logic              clash_arm_q;
	logic              fault_q;
	logic              fault_arm_q;
	logic              pready_q;
	logic [31:0]       prdata_q;
	logic              pslverr_q;
	logic              irq_q;
	spc_pin_out_type   pin_o_q;
	spc_pin_out_type   pin_oe_n_q;

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q    <= '1;
			sync2_q    <= '1;
			// same level as the synchroniser reset: no false edge after reset
			sck_prev_q <= 1'b1;
		end else begin
			sync1_q    <= pin_i;
			sync2_q    <= sync1_q;
			sck_prev_q <= sync2_q.sck;
		end
	end

	logic ss_low;
	logic slave_sel;
	assign ss_low    = ~sync2_q.ss_n;
	assign slave_sel = ctrl_q.on & ~ctrl_q.master & ss_low;

	// ****************************************
	// apb decode
	// ****************************************
	logic setup;
	logic acc;
	logic is_ctrl;
	logic is_stat;
	logic is_data;
	logic wr_ctrl;
	logic wr_data;
	logic data_acc;
	logic stat_acc;
	assign setup    = psel & ~penable;
	assign acc      = psel & penable & pready_q;
	assign is_ctrl  = (paddr == SPC_OFS_CTRL);
	assign is_stat  = (paddr == SPC_OFS_STAT);
	assign is_data  = (paddr == SPC_OFS_DATA);
	assign wr_ctrl  = acc & pwrite & is_ctrl;
	assign wr_data  = acc & pwrite & is_data;
	assign data_acc = acc & is_data;
	assign stat_acc = acc & is_stat;

	// one setup cycle, answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~(is_ctrl | is_stat | is_data);
			if (setup) begin
				prdata_q <= 32'h0;
				if (is_ctrl)
					prdata_q[7:0] <= ctrl_q;
				if (is_stat) begin
					prdata_q[SPC_ST_DONE]  <= done_q;
					prdata_q[SPC_ST_CLASH] <= clash_q;
					prdata_q[SPC_ST_FAULT] <= fault_q;
				end
				if (is_data)
					prdata_q[7:0] <= rx_q;
			end
		end
	end

	// ****************************************
	// serial edge timing
	// ****************************************
	logic m_tick;
	logic lead;
	logic trail;
	logic last;
	logic in_bit;
	logic s_chg;
	logic xfer_lock;
	logic wr_ok;
	logic fault_set;

	assign half   = spc_half_period({ctrl_q.rate2, ctrl_q.rate});
	assign m_tick = (state_q == SPC_RUN) & (div_q == half - 7'h01);
	assign s_chg  = slave_sel & (sync2_q.sck != sck_prev_q);
	// leading edge leaves the idle level, trailing edge returns to it
	assign lead   = ctrl_q.master ? m_tick & (sck_q == ctrl_q.idle_level)
	                              : s_chg & (sck_prev_q == ctrl_q.idle_level);
	assign trail  = ctrl_q.master ? m_tick & (sck_q != ctrl_q.idle_level)
	                              : s_chg & (sync2_q.sck == ctrl_q.idle_level);
	assign last   = trail & (bit_q == SPC_LAST_BIT);
	assign in_bit = ctrl_q.master ? sync2_q.miso : sync2_q.mosi;

	// slave with capture_edge_sel clear cannot see the first edge coming
	assign xfer_lock = ctrl_q.master ? (state_q == SPC_RUN)
	                                 : slave_sel & (~ctrl_q.capture_edge | locked_q);
	assign wr_ok     = wr_data & ~xfer_lock & ~(done_q & ~done_arm_q);
	assign fault_set = ctrl_q.master & ctrl_q.on & ss_low;

	// ****************************************
	// shift engine
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= SPC_IDLE;
			div_q    <= 7'h0;
			sck_q    <= 1'b0;
			bit_q    <= 3'h0;
			sh_q     <= SPC_DATA_RST;
			samp_q   <= 1'b0;
			out_q    <= 1'b0;
			locked_q <= 1'b0;
		end else if (!halt_mode) begin
			if (fault_set) begin
				state_q  <= SPC_IDLE;
				bit_q    <= 3'h0;
				locked_q <= 1'b0;
				sck_q    <= ctrl_q.idle_level;
			end else begin
				if (state_q == SPC_IDLE)
					sck_q <= ctrl_q.idle_level;
				if (~ctrl_q.capture_edge & (bit_q == 3'h0))
					out_q <= sh_q[7];
				if (wr_ok) begin
					sh_q <= pwdata[7:0];
					if (ctrl_q.master & ctrl_q.on) begin
						state_q <= SPC_RUN;
						div_q   <= 7'h0;
						bit_q   <= 3'h0;
					end
				end
				if (state_q == SPC_RUN) begin
					div_q <= m_tick ? 7'h0 : div_q + 7'h01;
					if (m_tick)
						sck_q <= ~sck_q;
				end
				if (lead) begin
					samp_q   <= in_bit;
					locked_q <= 1'b1;
					if (ctrl_q.capture_edge)
						out_q <= sh_q[7];
				end
				if (trail) begin
					// last received byte stays in sh_q and goes back out
					sh_q  <= {sh_q[6:0], ctrl_q.capture_edge ? in_bit : samp_q};
					bit_q <= bit_q + 3'h1;
					if (~ctrl_q.capture_edge)
						out_q <= sh_q[6];
				end
				if (last) begin
					state_q  <= SPC_IDLE;
					locked_q <= 1'b0;
				end
				if (~ctrl_q.master & ~ss_low) begin
					bit_q    <= 3'h0;
					locked_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// receive buffer and flags
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q       <= SPC_DATA_RST;
			done_q     <= 1'b0;
			done_arm_q <= 1'b0;
		end else if (!halt_mode) begin
			if (last & ~done_q)
				rx_q <= {sh_q[6:0], ctrl_q.capture_edge ? in_bit : samp_q};
			if (stat_acc & done_q)
				done_arm_q <= 1'b1;
			if (data_acc & done_arm_q) begin
				done_q     <= 1'b0;
				done_arm_q <= 1'b0;
			end
			if (last)
				done_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clash_q     <= 1'b0;
			clash_arm_q <= 1'b0;
		end else if (!halt_mode) begin
			if (stat_acc & ~pwrite & clash_q)
				clash_arm_q <= 1'b1;
			if (data_acc & clash_arm_q) begin
				clash_q     <= 1'b0;
				clash_arm_q <= 1'b0;
			end
			if (wr_data & xfer_lock)
				clash_q <= 1'b1;
		end
	end

	// ****************************************
	// control and fault
	// ****************************************
	always_comb begin
		ctrl_wr = pwdata[7:0];
		if (fault_q & ~fault_arm_q) begin
			ctrl_wr.on     = pwdata[6] & ctrl_q.on;
			ctrl_wr.master = pwdata[4] & ctrl_q.master;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= SPC_CTRL_RST;
			fault_q     <= 1'b0;
			fault_arm_q <= 1'b0;
		end else if (!halt_mode) begin
			if (stat_acc & fault_q)
				fault_arm_q <= 1'b1;
			if (wr_ctrl)
				ctrl_q <= ctrl_wr;
			if (wr_ctrl & fault_arm_q) begin
				fault_q     <= 1'b0;
				fault_arm_q <= 1'b0;
			end
			if (fault_set) begin
				fault_q       <= 1'b1;
				ctrl_q.on     <= 1'b0;
				ctrl_q.master <= 1'b0;
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_o_q    <= '0;
			pin_oe_n_q <= '1;
			irq_q      <= 1'b0;
		end else if (!halt_mode) begin
			pin_o_q.sck       <= sck_q;
			pin_o_q.mosi      <= out_q;
			pin_o_q.miso      <= out_q;
			pin_oe_n_q.sck    <= ~(ctrl_q.on & ctrl_q.master);
			pin_oe_n_q.mosi   <= ~(ctrl_q.on & ctrl_q.master);
			pin_oe_n_q.miso   <= ~slave_sel;
			// clash is status only; irq also serves as the wait wake-up
			irq_q <= ctrl_q.irq_en & (done_q | fault_q);
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign pin_o    = pin_o_q;
	assign pin_oe_n = pin_oe_n_q;
	assign irq      = irq_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_fault_entry;
		fault_set & ~halt_mode |=> fault_q & ~ctrl_q.on & ~ctrl_q.master;
	endproperty
	a_fault_entry: assert property (p_fault_entry) else $error("fault entry wrong");

	property p_slave_no_fault;
		~fault_q & ~ctrl_q.master |=> ~fault_q;
	endproperty
	a_slave_no_fault: assert property (p_slave_no_fault) else $error("slave set fault");

	property p_clash_quiet;
		(clash_q & ~done_q & ~fault_q)[*2] |-> ~irq_q;
	endproperty
	a_clash_quiet: assert property (p_clash_quiet) else $error("clash raised irq");

	property p_irq_on;
		ctrl_q.irq_en & (done_q | fault_q) & ~halt_mode |=> irq_q;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing");

	property p_run_clash;
		wr_data & (state_q == SPC_RUN) & ~halt_mode & ~last & ~fault_set
			|=> clash_q & (state_q == SPC_RUN);
	endproperty
	a_run_clash: assert property (p_run_clash) else $error("run write not a clash");

	property p_slave_lock;
		wr_data & slave_sel & ~ctrl_q.capture_edge & ~halt_mode |=> clash_q;
	endproperty
	a_slave_lock: assert property (p_slave_lock) else $error("slave lock missed");

	property p_keep_first;
		done_q & ~halt_mode |=> $stable(rx_q);
	endproperty
	a_keep_first: assert property (p_keep_first) else $error("buffer overwritten");

	property p_done_set;
		last & ~halt_mode |=> done_q;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set");

	property p_fault_block;
		wr_ctrl & fault_q & ~fault_arm_q & ~ctrl_q.on & ~halt_mode |=> ~ctrl_q.on;
	endproperty
	a_fault_block: assert property (p_fault_block) else $error("on set during fault");

	property p_halt_freeze;
		halt_mode |=> $stable(ctrl_q) & $stable(sh_q) & $stable(done_q);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("state moved in halt");

endmodule

// File: shared/spc_pkg.sv
package spc_pkg;

	// ****************************************
	// bus map
	// ****************************************
	localparam int          SPC_ADDR_W   = 4;
	localparam logic [3:0]  SPC_OFS_CTRL = 4'h0;
	localparam logic [3:0]  SPC_OFS_STAT = 4'h4;
	localparam logic [3:0]  SPC_OFS_DATA = 4'h8;
	localparam logic [7:0]  SPC_CTRL_RST = 8'h00;
	localparam logic [7:0]  SPC_DATA_RST = 8'h00;
	localparam int          SPC_ST_DONE  = 7;
	localparam int          SPC_ST_CLASH = 6;
	localparam int          SPC_ST_FAULT = 4;

	// ****************************************
	// framing
	// ****************************************
	localparam logic [2:0]  SPC_LAST_BIT = 3'h7;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic       irq_en;
		logic       on;
		logic       rate2;
		logic       master;
		logic       idle_level;
		logic       capture_edge;
		logic [1:0] rate;
	} spc_ctrl_type;

	typedef struct packed {
		logic sck;
		logic ss_n;
		logic mosi;
		logic miso;
	} spc_pin_in_type;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
	} spc_pin_out_type;

	typedef enum logic {SPC_IDLE, SPC_RUN} spc_mst_state_type;

	// half serial clock period in pclk cycles, from {rate2, rate}
	function automatic logic [6:0] spc_half_period(input logic [2:0] sel);
		unique case (sel)
			3'h4:    spc_half_period = 7'h02;
			3'h0:    spc_half_period = 7'h04;
			3'h1:    spc_half_period = 7'h08;
			3'h6:    spc_half_period = 7'h10;
			3'h2:    spc_half_period = 7'h20;
			3'h3:    spc_half_period = 7'h40;
			default: spc_half_period = 7'h04;
		endcase
	endfunction

endpackage
